//--- verification/vpc_top_bench.sv
`timescale 1ns/1ps
// ==========================================
// Bench top
module vpc_top_bench;
  import vpc_pkg::*;
  typedef struct {int due; int kind; logic [31:0] val;} vpc_note_type;
  logic        sys_clk = 1'h0, rst = 1'h1, clk_en = 1'h1, cfg_wr = 1'h0, swap_push = 1'h0;
  logic        frame_start = 1'h0, line_start = 1'h0, even_field = 1'h0;
  logic [31:0] cfg_wdata = '0, cur_w = '0, lfsr = 32'hF218;
  logic [23:0] left_overlay_addr = '0, right_overlay_addr = '0, video_in_addr = '0;
  logic [23:0] desktop_start_addr = '0, desk_pixel = '0, key_min = '0, key_max = '0;
  logic [13:0] desktop_stride = '0;
  logic [19:0] overlay_hscale_step = '0, overlay_vscale_step = '0, overlay_voffset_init = '0;
  logic [31:0] video_config_word;
  logic        swap_ready, vp_active, vga_active, cursor_xstyle, cursor_show, stereo_eye;
  logic        desk_fetch_en, ovl_fetch_en, desk_transparent, desk_lut_bypass, ovl_lut_bypass;
  logic        desk_lut_upper, ovl_lut_upper, desk_tiled, ovl_tiled, pixels_per_clk2;
  logic        desk_opt_en, ovl_opt_en;
  logic [23:0] overlay_start, desk_fetch_addr;
  logic [19:0] hscale_step, vscale_step, voffset_init;
  logic [1:0]  filter_mode;
  logic [3:0]  desk_bpp_sel;
  logic [4:0]  ovl_fmt_sel;
  int          cyc = 0, err_total = 0, checked = 0;
  vpc_note_type notes[$];
  vpc_note_type nt;

  vpc_top dut (.*);

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  // ==========================================
  // Helpers
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [3:0] bpp(input logic [2:0] c);
    return (c < 3'h4) ? 4'h1 << c : 4'h0;
  endfunction
  function automatic logic [4:0] ofm(input logic [2:0] c);
    return (c == 3'h1) ? 5'h01 : (c[2] ? 5'h02 << c[1:0] : 5'h00);
  endfunction
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic note(input int kind, input logic [31:0] v, input int dly);
    notes.push_back('{cyc + dly, kind, v});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [31:0] w, input bit hold);
    w[3] = 1'h0;
    w[26] = w[26] & ~w[31];
    cfg_wdata = w;
    cfg_wr = 1'h1;
    cur_w = w & 32'hBFFFFFF7;
    step(1);
    note(0, cur_w, 1);
    if (!hold) begin
      cfg_wr = 1'h0;
      step(1);
    end
  endtask
  task automatic pulse_frame;
    frame_start = 1'h1;
    step(1);
    frame_start = 1'h0;
    step(3);
  endtask
  task automatic end_of_test;
    if (err_total == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================
  // Result watcher
  always @(negedge sys_clk) begin
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      nt = notes.pop_front();
      case (nt.kind)
        0: begin
          cmp("word", nt.val, video_config_word);
          cmp("vp", nt.val[0], vp_active);
          cmp("vga", !nt.val[0], vga_active);
          cmp("xstyle", nt.val[1], cursor_xstyle);
          cmp("cursor", nt.val[27] & nt.val[0], cursor_show);
          cmp("fetch", {nt.val[8] & nt.val[0], nt.val[7] & nt.val[0]},
              {ovl_fetch_en, desk_fetch_en});
          cmp("lut", nt.val[13:10],
              {ovl_lut_upper, desk_lut_upper, ovl_lut_bypass, desk_lut_bypass});
          cmp("filter", nt.val[17:16], filter_mode);
          cmp("dfmt", bpp(nt.val[20:18]), desk_bpp_sel);
          cmp("ofmt", ofm(nt.val[23:21]), ovl_fmt_sel);
          cmp("tile", nt.val[25:24], {ovl_tiled, desk_tiled});
          cmp("double", nt.val[26], pixels_per_clk2);
          cmp("opt", {!nt.val[29], !nt.val[28]}, {ovl_opt_en, desk_opt_en});
        end
        1: cmp("transparent", nt.val[0], desk_transparent);
        2: cmp("ovl_start", nt.val[23:0], overlay_start);
        3: cmp("fetch_addr", nt.val[23:0], desk_fetch_addr);
        4: begin
          cmp("eye", nt.val[24], stereo_eye);
          cmp("stereo", nt.val[23:0], overlay_start);
        end
        5: cmp("ready", nt.val[0], swap_ready);
        default: cmp("voffset", nt.val[19:0], voffset_init);
      endcase
    end
  end

  // ==========================================
  // Watchdog
  initial begin
    repeat (6000) @(posedge sys_clk);
    err_total++;
    end_of_test();
  end

  // ==========================================
  // Main sequence
  initial begin
    step(8);
    rst = 1'h0;
    note(0, 32'h00000000, 1);
    step(2);
    for (int i = 0; i < 24; i++) begin
      lfsr = nxt(lfsr);
      wr(i < 8 ? {lfsr[31:24], i[2:0], i[2:0], i[1:0], lfsr[15:0]} : lfsr, i < 23);
    end
    step(2);
    for (int m = 0; m < 4; m++) begin
      lfsr = nxt(lfsr);
      wr({lfsr[31:7], m[1:0], lfsr[4:0]}, 1'b0);
      for (int i = 0; i < 12; i++) begin
        lfsr = nxt(lfsr);
        desk_pixel = lfsr[23:0];
        key_min = lfsr[24] ? lfsr[23:0] : lfsr[23:0] ^ 24'h010101;
        key_max = key_min;
        even_field = lfsr[26];
        overlay_hscale_step = lfsr[19:0];
        overlay_vscale_step = lfsr[31:12];
        overlay_voffset_init = lfsr[27:8];
        step(1);
        note(1, {31'h0, cur_w[5] & (lfsr[24] ^ cur_w[6])}, 0);
      end
    end
    wr(32'h80038101, 1'b0);
    overlay_voffset_init = 20'h00400;
    overlay_vscale_step = 20'h00800;
    for (int i = 0; i < 4; i++) begin
      even_field = i[0];
      step(1);
      note(6, {12'h000, i[0] ? 20'h00C00 : 20'h00400}, 0);
    end
    for (int h = 0; h < 2; h++) begin
      wr(32'h00000081 | (h << 4), 1'b0);
      lfsr = nxt(lfsr);
      desktop_start_addr = lfsr[23:0];
      desktop_stride = lfsr[31:18];
      pulse_frame();
      repeat (5) begin
        line_start = 1'h1;
        step(1);
        line_start = 1'h0;
        step(1);
      end
      step(2);
      note(3, desktop_start_addr + desktop_stride * (h ? 24'h2 : 24'h5), 0);
    end
    wr(32'h00000181, 1'b0);
    lfsr = nxt(lfsr);
    left_overlay_addr = lfsr[23:0];
    right_overlay_addr = ~lfsr[23:0];
    video_in_addr = lfsr[31:8];
    swap_push = 1'h1;
    step(1);
    swap_push = 1'h0;
    pulse_frame();
    note(2, left_overlay_addr, 0);
    wr(32'h00000381, 1'b0);
    pulse_frame();
    note(2, video_in_addr, 0);
    wr(32'h00000185, 1'b0);
    lfsr = nxt(lfsr);
    left_overlay_addr = lfsr[23:0];
    right_overlay_addr = lfsr[31:8];
    swap_push = 1'h1;
    step(1);
    swap_push = 1'h0;
    for (int i = 0; i < 5; i++) begin
      pulse_frame();
      if (i >= 2) note(4, {7'h00, ~i[0], i[0] ? left_overlay_addr : right_overlay_addr}, 0);
    end
    note(5, 32'h00000001, 0);
    for (int i = 0; i < 2; i++) begin
      lfsr = nxt(lfsr);
      left_overlay_addr = lfsr[23:0];
      right_overlay_addr = lfsr[31:8];
      swap_push = 1'h1;
      step(1);
    end
    swap_push = 1'h0;
    step(2);
    note(5, 32'h00000000, 0);
    step(4);
    end_of_test();
  end
endmodule

bind vpc_top vpc_top_props u_props (.*);

//--- verification/vpc_top_props.sv
`timescale 1ns/1ps
// ==========================================
// Port checker
module vpc_top_props (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic        cfg_wr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] video_config_word,
  input wire logic        frame_start,
  input wire logic        even_field,
  input wire logic [19:0] overlay_hscale_step,
  input wire logic [19:0] overlay_vscale_step,
  input wire logic [19:0] overlay_voffset_init,
  input wire logic        vp_active,
  input wire logic        vga_active,
  input wire logic        cursor_xstyle,
  input wire logic        cursor_show,
  input wire logic        stereo_eye,
  input wire logic        desk_fetch_en,
  input wire logic        ovl_fetch_en,
  input wire logic [19:0] hscale_step,
  input wire logic [19:0] vscale_step,
  input wire logic [19:0] voffset_init,
  input wire logic        desk_opt_en,
  input wire logic        ovl_opt_en
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Properties
  property p_cfg_rd;
    (cfg_wr && clk_en) |-> ##2 video_config_word == ($past(cfg_wdata, 2) & 32'hBFFFFFF7);
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");
  property p_vp;
    vp_active == video_config_word[0] && vga_active == !video_config_word[0];
  endproperty
  a_vp: assert property (p_vp) else $error("display select wrong");
  property p_cur;
    cursor_show == (video_config_word[27] && video_config_word[0])
      && cursor_xstyle == video_config_word[1];
  endproperty
  a_cur: assert property (p_cur) else $error("cursor control wrong");
  property p_fetch;
    desk_fetch_en == (video_config_word[7] && video_config_word[0])
      && ovl_fetch_en == (video_config_word[8] && video_config_word[0]);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch enable wrong");
  property p_opt;
    desk_opt_en == !video_config_word[28] && ovl_opt_en == !video_config_word[29];
  endproperty
  a_opt: assert property (p_opt) else $error("optimization enable wrong");
  property p_eye_off;
    (!video_config_word[2] && !$past(video_config_word[2])) |-> !stereo_eye;
  endproperty
  a_eye_off: assert property (p_eye_off) else $error("eye high in mono");
  property p_eye_alt;
    (frame_start && clk_en && video_config_word[2] && $past(video_config_word[2]))
      |-> ##[1:2] $changed(stereo_eye);
  endproperty
  a_eye_alt: assert property (p_eye_alt) else $error("eye did not alternate");
  property p_bob;
    !$past(rst) |-> voffset_init == $past(overlay_voffset_init)
      + ((video_config_word[31] && $past(even_field)) ? 20'h00800 : 20'h00000);
  endproperty
  a_bob: assert property (p_bob) else $error("bob offset wrong");
  property p_scale;
    !$past(rst) |-> hscale_step == (video_config_word[14] ? $past(overlay_hscale_step) : 20'h0)
      && vscale_step == (video_config_word[15] ? $past(overlay_vscale_step) : 20'h0);
  endproperty
  a_scale: assert property (p_scale) else $error("scale step wrong");
endmodule

//--- verilog/vpc_cfg.svh
`ifndef VPC_CFG_SVH
`define VPC_CFG_SVH
// ==========================================
// Configuration word field positions
`define VPC_VP_ON_BIT        0
`define VPC_CUR_XSTYLE_BIT   1
`define VPC_STEREO_BIT       2
`define VPC_INTERLACE_BIT    3
`define VPC_HALF_BIT         4
`define VPC_KEY_EN_BIT       5
`define VPC_KEY_INV_BIT      6
`define VPC_DESK_EN_BIT      7
`define VPC_OVL_EN_BIT       8
`define VPC_VIN_OVL_BIT      9
`define VPC_DESK_BYP_BIT     10
`define VPC_OVL_BYP_BIT      11
`define VPC_DESK_SEL_BIT     12
`define VPC_OVL_SEL_BIT      13
`define VPC_HSCALE_BIT       14
`define VPC_VSCALE_BIT       15
`define VPC_FILT_LSB         16
`define VPC_FILT_MSB         17
`define VPC_DFMT_LSB         18
`define VPC_DFMT_MSB         20
`define VPC_OFMT_LSB         21
`define VPC_OFMT_MSB         23
`define VPC_DESK_TILE_BIT    24
`define VPC_OVL_TILE_BIT     25
`define VPC_DOUBLE_BIT       26
`define VPC_CURSOR_BIT       27
`define VPC_DESK_NOOPT_BIT   28
`define VPC_OVL_NOOPT_BIT    29
`define VPC_BOB_BIT          31
// ==========================================
// Reset values and constants
`define VPC_CFG_RESET        32'h00000000
`define VPC_RSVD_MASK        32'h40000008
`define VPC_HALF_STEP        20'h00800
`endif

//--- verilog/vpc_pkg.sv
package vpc_pkg;
  typedef enum logic [1:0] {
    VPC_FILT_POINT = 2'b00,
    VPC_FILT_BOX   = 2'b01,
    VPC_FILT_TAP   = 2'b10,
    VPC_FILT_BILIN = 2'b11
  } vpc_filt_type;
  typedef enum logic [2:0] {
    VPC_DFMT_PAL8  = 3'b000,
    VPC_DFMT_565   = 3'b001,
    VPC_DFMT_RGB24 = 3'b010,
    VPC_DFMT_RGB32 = 3'b011
  } vpc_dfmt_type;
  typedef enum logic [2:0] {
    VPC_OFMT_565U  = 3'b001,
    VPC_OFMT_Y411  = 3'b100,
    VPC_OFMT_YUYV  = 3'b101,
    VPC_OFMT_UYVY  = 3'b110,
    VPC_OFMT_565D  = 3'b111
  } vpc_ofmt_type;
  typedef enum logic [0:0] {
    VPC_EYE_LEFT  = 1'b0,
    VPC_EYE_RIGHT = 1'b1
  } vpc_eye_type;
endpackage

//--- verilog/vpc_swap_queue.sv
`timescale 1ns/1ps
`include "vpc_cfg.svh"
// Two-entry queue of left/right overlay address pairs
module vpc_swap_queue
  import vpc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        push,
  input  wire logic [23:0] left_in,
  input  wire logic [23:0] right_in,
  input  wire logic        pop,
  output logic             full,
  output logic             avail,
  output logic      [23:0] left_out,
  output logic      [23:0] right_out
);
  logic [47:0] mem_q [0:1];
  logic [47:0] mem_d [0:1];
  logic        wp_q, wp_d, rp_q, rp_d;
  logic [1:0]  cnt_q, cnt_d;
  logic        do_push, do_pop;

  always_comb begin
    do_pop   = pop && (cnt_q != 2'd0);
    do_push  = push && ((cnt_q != 2'd2) || do_pop);
    mem_d[0] = mem_q[0];
    mem_d[1] = mem_q[1];
    wp_d     = wp_q;
    rp_d     = rp_q;
    cnt_d    = cnt_q;
    if (do_push) begin
      mem_d[wp_q] = {right_in, left_in};
      wp_d        = ~wp_q;
    end
    if (do_pop) begin
      rp_d = ~rp_q;
    end
    cnt_d = cnt_q + {1'b0, do_push} - {1'b0, do_pop};
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_q[0] <= 48'h000000000000;
      mem_q[1] <= 48'h000000000000;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'd0;
    end else if (clk_en) begin
      mem_q[0] <= mem_d[0];
      mem_q[1] <= mem_d[1];
      wp_q     <= wp_d;
      rp_q     <= rp_d;
      cnt_q    <= cnt_d;
    end
  end

  assign full      = (cnt_q == 2'd2);
  assign avail     = (cnt_q != 2'd0);
  assign left_out  = mem_q[rp_q][23:0];
  assign right_out = mem_q[rp_q][47:24];
endmodule

//--- verilog/vpc_top.sv
// ==========================================
// Overview of operation
// - Bit 0 selects video processor or VGA
// - Bit 1 picks cursor colour convention
// - Stereo alternates left/right, drives eye output
// - Half mode steps stride every second line
// - Colour key enable and inverted sense
// - Surface fetch only when enabled
// - Video-in address becomes overlay start
// - Lookup bypass and table half select
// - Scaling uses step only when enabled
// - Filter field selects four filter modes
// - Desktop pixel format decode
// - Overlay pixel format decode
// - Linear or tiled addressing per surface
// - Double-pixel mode gives two pixels/clock
// - Cursor shown only when enabled
// - Memory optimization disable bits
// - Bob adds half to even-field offset
// - Stereo off uses left, eye low
`timescale 1ns/1ps
`include "vpc_cfg.svh"
module vpc_top
  import vpc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic        cfg_wr,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] video_config_word,
  input  wire logic        swap_push,
  input  wire logic [23:0] left_overlay_addr,
  input  wire logic [23:0] right_overlay_addr,
  output logic             swap_ready,
  input  wire logic        frame_start,
  input  wire logic        line_start,
  input  wire logic        even_field,
  input  wire logic [23:0] video_in_addr,
  input  wire logic [23:0] desktop_start_addr,
  input  wire logic [13:0] desktop_stride,
  input  wire logic [19:0] overlay_hscale_step,
  input  wire logic [19:0] overlay_vscale_step,
  input  wire logic [19:0] overlay_voffset_init,
  input  wire logic [23:0] desk_pixel,
  input  wire logic [23:0] key_min,
  input  wire logic [23:0] key_max,
  output logic             vp_active,
  output logic             vga_active,
  output logic             cursor_xstyle,
  output logic             cursor_show,
  output logic             stereo_eye,
  output logic      [23:0] overlay_start,
  output logic      [23:0] desk_fetch_addr,
  output logic             desk_fetch_en,
  output logic             ovl_fetch_en,
  output logic             desk_transparent,
  output logic             desk_lut_bypass,
  output logic             ovl_lut_bypass,
  output logic             desk_lut_upper,
  output logic             ovl_lut_upper,
  output logic      [19:0] hscale_step,
  output logic      [19:0] vscale_step,
  output logic      [19:0] voffset_init,
  output logic      [1:0]  filter_mode,
  output logic      [3:0]  desk_bpp_sel,
  output logic      [4:0]  ovl_fmt_sel,
  output logic             desk_tiled,
  output logic             ovl_tiled,
  output logic             pixels_per_clk2,
  output logic             desk_opt_en,
  output logic             ovl_opt_en
);
  // ==========================================
  // Configuration word
  logic [31:0] cfg_q, cfg_d;

  always_comb begin
    cfg_d = cfg_q;
    if (cfg_wr) begin
      cfg_d = cfg_wdata & ~`VPC_RSVD_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_q <= `VPC_CFG_RESET;
    end else if (clk_en) begin
      cfg_q <= cfg_d;
    end
  end

  // ==========================================
  // Decode helpers
  function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [3:0] dfmt_dec(input logic [2:0] f);
    dfmt_dec = 4'h0;
    case (f)
      VPC_DFMT_PAL8:  dfmt_dec = 4'h1;
      VPC_DFMT_565:   dfmt_dec = 4'h2;
      VPC_DFMT_RGB24: dfmt_dec = 4'h4;
      VPC_DFMT_RGB32: dfmt_dec = 4'h8;
      default:        dfmt_dec = 4'h0;
    endcase
  endfunction

  function automatic logic [4:0] ofmt_dec(input logic [2:0] f);
    ofmt_dec = 5'h00;
    case (f)
      VPC_OFMT_565U: ofmt_dec = 5'h01;
      VPC_OFMT_Y411: ofmt_dec = 5'h02;
      VPC_OFMT_YUYV: ofmt_dec = 5'h04;
      VPC_OFMT_UYVY: ofmt_dec = 5'h08;
      VPC_OFMT_565D: ofmt_dec = 5'h10;
      default:       ofmt_dec = 5'h00;
    endcase
  endfunction

  // ==========================================
  // Swap address queue
  logic        q_full, q_avail;
  logic [23:0] q_left, q_right;
  logic        q_pop;

  vpc_swap_queue u_queue (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .push      (swap_push),
    .left_in   (left_overlay_addr),
    .right_in  (right_overlay_addr),
    .pop       (q_pop),
    .full      (q_full),
    .avail     (q_avail),
    .left_out  (q_left),
    .right_out (q_right)
  );

  // ==========================================
  // Refresh state: eye, current pair, line parity
  logic        eye_q, eye_d;
  logic [23:0] cur_left_q, cur_left_d, cur_right_q, cur_right_d;
  logic        line_odd_q, line_odd_d;
  logic [23:0] line_addr_q, line_addr_d;
  logic        stereo_on;

  always_comb begin
    stereo_on   = cfg_q[`VPC_STEREO_BIT];
    eye_d       = eye_q;
    cur_left_d  = cur_left_q;
    cur_right_d = cur_right_q;
    line_odd_d  = line_odd_q;
    line_addr_d = line_addr_q;
    q_pop       = 1'b0;
    if (frame_start) begin
      eye_d = stereo_on ? ~eye_q : VPC_EYE_LEFT;
      // new pair taken only at frame start
      if (q_avail && (!stereo_on || eye_q == VPC_EYE_RIGHT)) begin
        q_pop       = 1'b1;
        cur_left_d  = q_left;
        cur_right_d = q_right;
      end
      line_odd_d  = 1'b0;
      line_addr_d = desktop_start_addr;
    end else if (line_start) begin
      line_odd_d = ~line_odd_q;
      // half mode skips every other advance
      if (!cfg_q[`VPC_HALF_BIT] || line_odd_q) begin
        line_addr_d = line_addr_q + {10'h000, desktop_stride};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      eye_q       <= 1'b0;
      cur_left_q  <= 24'h000000;
      cur_right_q <= 24'h000000;
      line_odd_q  <= 1'b0;
      line_addr_q <= 24'h000000;
    end else if (clk_en) begin
      eye_q       <= eye_d;
      cur_left_q  <= cur_left_d;
      cur_right_q <= cur_right_d;
      line_odd_q  <= line_odd_d;
      line_addr_q <= line_addr_d;
    end
  end

  // ==========================================
  // Registered outputs
  logic [23:0] ovl_d;
  logic        key_hit, transp_d;
  logic [19:0] voff_d;

  always_comb begin
    // video-in address when bit 9 set, else left address when stereo off
    if (cfg_q[`VPC_VIN_OVL_BIT]) begin
      ovl_d = video_in_addr;
    end else if (stereo_on && eye_q == VPC_EYE_RIGHT) begin
      ovl_d = cur_right_q;
    end else begin
      ovl_d = cur_left_q;
    end
    key_hit = in_range(desk_pixel[7:0], key_min[7:0], key_max[7:0]) &&
              in_range(desk_pixel[15:8], key_min[15:8], key_max[15:8]) &&
              in_range(desk_pixel[23:16], key_min[23:16], key_max[23:16]);
    transp_d = cfg_q[`VPC_KEY_EN_BIT] && (key_hit ^ cfg_q[`VPC_KEY_INV_BIT]);
    // bob adds half on even field
    voff_d = overlay_voffset_init;
    if (cfg_q[`VPC_BOB_BIT] && even_field) begin
      voff_d = overlay_voffset_init + `VPC_HALF_STEP;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      video_config_word <= 32'h00000000;
      swap_ready        <= 1'b0;
      vp_active         <= 1'b0;
      vga_active        <= 1'b1;
      cursor_xstyle     <= 1'b0;
      cursor_show       <= 1'b0;
      stereo_eye        <= 1'b0;
      overlay_start     <= 24'h000000;
      desk_fetch_addr   <= 24'h000000;
      desk_fetch_en     <= 1'b0;
      ovl_fetch_en      <= 1'b0;
      desk_transparent  <= 1'b0;
      desk_lut_bypass   <= 1'b0;
      ovl_lut_bypass    <= 1'b0;
      desk_lut_upper    <= 1'b0;
      ovl_lut_upper     <= 1'b0;
      hscale_step       <= 20'h00000;
      vscale_step       <= 20'h00000;
      voffset_init      <= 20'h00000;
      filter_mode       <= 2'b00;
      desk_bpp_sel      <= 4'h0;
      ovl_fmt_sel       <= 5'h00;
      desk_tiled        <= 1'b0;
      ovl_tiled         <= 1'b0;
      pixels_per_clk2   <= 1'b0;
      desk_opt_en       <= 1'b1;
      ovl_opt_en        <= 1'b1;
    end else if (clk_en) begin
      video_config_word <= cfg_q;
      swap_ready        <= !q_full;
      vp_active         <= cfg_q[`VPC_VP_ON_BIT];
      vga_active        <= !cfg_q[`VPC_VP_ON_BIT];
      cursor_xstyle     <= cfg_q[`VPC_CUR_XSTYLE_BIT];
      cursor_show       <= cfg_q[`VPC_CURSOR_BIT] && cfg_q[`VPC_VP_ON_BIT];
      stereo_eye        <= stereo_on && eye_q;
      overlay_start     <= ovl_d;
      desk_fetch_addr   <= line_addr_q;
      desk_fetch_en     <= cfg_q[`VPC_DESK_EN_BIT] && cfg_q[`VPC_VP_ON_BIT];
      ovl_fetch_en      <= cfg_q[`VPC_OVL_EN_BIT] && cfg_q[`VPC_VP_ON_BIT];
      desk_transparent  <= transp_d;
      desk_lut_bypass   <= cfg_q[`VPC_DESK_BYP_BIT];
      ovl_lut_bypass    <= cfg_q[`VPC_OVL_BYP_BIT];
      desk_lut_upper    <= cfg_q[`VPC_DESK_SEL_BIT];
      ovl_lut_upper     <= cfg_q[`VPC_OVL_SEL_BIT];
      hscale_step       <= cfg_q[`VPC_HSCALE_BIT] ? overlay_hscale_step : 20'h00000;
      vscale_step       <= cfg_q[`VPC_VSCALE_BIT] ? overlay_vscale_step : 20'h00000;
      voffset_init      <= voff_d;
      filter_mode       <= cfg_q[`VPC_FILT_MSB:`VPC_FILT_LSB];
      desk_bpp_sel      <= dfmt_dec(cfg_q[`VPC_DFMT_MSB:`VPC_DFMT_LSB]);
      ovl_fmt_sel       <= ofmt_dec(cfg_q[`VPC_OFMT_MSB:`VPC_OFMT_LSB]);
      desk_tiled        <= cfg_q[`VPC_DESK_TILE_BIT];
      ovl_tiled         <= cfg_q[`VPC_OVL_TILE_BIT];
      pixels_per_clk2   <= cfg_q[`VPC_DOUBLE_BIT];
      desk_opt_en       <= !cfg_q[`VPC_DESK_NOOPT_BIT];
      ovl_opt_en        <= !cfg_q[`VPC_OVL_NOOPT_BIT];
    end
  end
endmodule
